// file: core/sspc_pkg.sv
// shared constants and types of the standby/suspend power control block
package sspc_pkg;

    // ====================================================================
    // register map
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h01;
    localparam logic [7:0] CTRL_RESET    = 8'h00;

    // ====================================================================
    // control field positions
    localparam int AUTO_PD_DIS_BIT  = 7;
    localparam int ACT_WAKE_BIT     = 6;
    localparam int MEM_WAKE_BIT     = 5;
    localparam int SUSP_CLK_SRC_BIT = 4;

    // ====================================================================
    // status field positions
    localparam int STAT_STATE_LSB   = 0;
    localparam int STAT_EXPIRED_BIT = 2;

    // ====================================================================
    // timing
    localparam int CLK_PERIOD_NS       = 20;
    localparam int STANDBY_TIMEOUT_US  = 100;
    localparam int STANDBY_TIMEOUT_CYC = (STANDBY_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
    localparam int OSC_DIV_RATIO       = 432;
    localparam int OSC_HALF_DIV        = OSC_DIV_RATIO / 2;

    // ====================================================================
    // power states
    typedef enum logic [1:0] {
        ST_ACTIVE  = 2'b00,
        ST_STANDBY = 2'b01,
        ST_SUSPEND = 2'b10
    } sspc_state_t;

endpackage

// file: core/sspc_pm_if.sv
// signals between the power controller, its standby timer and its clock divider
`timescale 1ns/1ps
`default_nettype none
interface sspc_pm_if;
    logic restart;   // restart the standby count
    logic enable;    // count allowed
    logic expired;   // count reached the timeout
    logic oscEdge;   // one rising edge seen on the oscillator
    logic divEnable; // divider running
    logic divClk;    // divided slow clock

    modport ctrl    (output restart, output enable, input expired,
                     output oscEdge, output divEnable, input divClk);
    modport timer   (input restart, input enable, output expired);
    modport divider (input oscEdge, input divEnable, output divClk);
endinterface
`default_nettype wire

// file: core/sspc_standby_timer.sv
// inactivity counter that flags expiry of the standby timeout
`timescale 1ns/1ps
`default_nettype none
module sspc_standby_timer #(
    parameter int TIMEOUT_CYC = sspc_pkg::STANDBY_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // controller side
    sspc_pm_if.timer  pm
);
    localparam int CW = $clog2(TIMEOUT_CYC + 1);
    localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT_CYC);

    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;

    // ====================================================================
    // count idle cycles, clear on any restart
    always_comb begin
        count_d = count_q;
        if (!pm.enable || pm.restart) begin
            count_d = '0;
        end else if (count_q != LIMIT) begin
            count_d = count_q + CW'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign pm.expired = (count_q == LIMIT);

    // ====================================================================
    // checks
    timerRestart_a : assert property (@(posedge sys_clk) disable iff (rst)
        pm.restart |=> (count_q == '0))
        else $error("standby count not cleared by restart");
    timerAdvance_a : assert property (@(posedge sys_clk) disable iff (rst)
        (pm.enable && !pm.restart && !pm.expired) |=> (count_q == $past(count_q) + CW'(1)))
        else $error("standby count did not advance");
endmodule
`default_nettype wire

// file: core/sspc_clk_div.sv
// divides oscillator edges down to the suspend slow clock
`timescale 1ns/1ps
`default_nettype none
module sspc_clk_div #(
    parameter int HALF_DIV = sspc_pkg::OSC_HALF_DIV
) (
    // clock and reset
    input  wire logic  sys_clk,
    input  wire logic  rst,
    // controller side
    sspc_pm_if.divider pm
);
    localparam int DW = $clog2(HALF_DIV);
    localparam logic [DW-1:0] LAST = DW'(HALF_DIV - 1);

    logic [DW-1:0] cnt_q;
    logic [DW-1:0] cnt_d;
    logic          clk_q;
    logic          clk_d;

    // ====================================================================
    // toggle output every half period of oscillator edges
    always_comb begin
        cnt_d = cnt_q;
        clk_d = clk_q;
        if (!pm.divEnable) begin
            cnt_d = '0;
            clk_d = 1'b0;
        end else if (pm.oscEdge) begin
            if (cnt_q == LAST) begin
                cnt_d = '0;
                clk_d = ~clk_q;
            end else begin
                cnt_d = cnt_q + DW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_q <= '0;
            clk_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
        end
    end

    assign pm.divClk = clk_q;

    // ====================================================================
    // checks
    divToggle_a : assert property (@(posedge sys_clk) disable iff (rst)
        (pm.divEnable && pm.oscEdge && cnt_q == LAST) |=> (clk_q != $past(clk_q)))
        else $error("slow clock did not toggle after half ratio");
    divHold_a : assert property (@(posedge sys_clk) disable iff (rst)
        (pm.divEnable && !(pm.oscEdge && cnt_q == LAST)) |=> (clk_q == $past(clk_q)))
        else $error("slow clock toggled early");
endmodule
`default_nettype wire

// file: core/sspc_power_ctrl.sv
// standby timer, wake events and suspend clock control of a display controller
`timescale 1ns/1ps
`default_nettype none
module sspc_power_ctrl #(
    parameter int TIMEOUT_CYC = sspc_pkg::STANDBY_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdData,
    // activity sources
    input  wire logic       activityInput,
    input  wire logic       memAccessValid,
    input  wire logic       suspendRequest,
    // oscillator and slow clock pin
    input  wire logic       referenceOscillatorInput,
    output logic            refOscEnable,
    input  wire logic       slowClockInput,
    output logic            suspendStatusOutN,
    output logic            slowClockOe,
    output logic            suspendClock,
    // display power controls
    output logic            displayClkEnable,
    output logic            paletteEnable,
    output logic            panelPowerUpStart
);
    sspc_pm_if pm ();

    sspc_pkg::sspc_state_t state_q;
    sspc_pkg::sspc_state_t state_d;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;
    logic       actPrev_q;
    logic       oscPrev_q;
    logic       actEvt;
    logic       actRestart;
    logic       memRestart;
    logic       wake;
    logic       powerUp_d;
    logic       dispEn_q;
    logic       dispEn_d;
    logic       refOscEn_q;
    logic       refOscEn_d;
    logic       pinOe_q;
    logic       pinOe_d;
    logic       suspClk_q;
    logic       suspClk_d;
    logic       powerUp_q;

    // register decode shared by read and write paths
    function automatic logic isCtrl(input logic [7:0] addr);
        return addr == sspc_pkg::CTRL_OFFSET;
    endfunction

    // ====================================================================
    // sub-blocks
    sspc_standby_timer #(
        .TIMEOUT_CYC (TIMEOUT_CYC)
    ) u_timer (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pm      (pm.timer)
    );

    sspc_clk_div #(
        .HALF_DIV (sspc_pkg::OSC_HALF_DIV)
    ) u_div (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pm      (pm.divider)
    );

    // ====================================================================
    // registers: control write, status and control read
    always_comb begin
        ctrl_d   = ctrl_q;
        rdData_d = 8'h00;
        if (regWr && isCtrl(regAddr)) begin
            ctrl_d = regWrData;
        end
        if (regRd) begin
            if (isCtrl(regAddr)) begin
                rdData_d = ctrl_q;
            end else if (regAddr == sspc_pkg::STATUS_OFFSET) begin
                rdData_d[sspc_pkg::STAT_STATE_LSB +: 2] = state_q;
                rdData_d[sspc_pkg::STAT_EXPIRED_BIT]    = pm.expired;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q   <= sspc_pkg::CTRL_RESET;
            rdData_q <= 8'h00;
        end else begin
            ctrl_q   <= ctrl_d;
            rdData_q <= rdData_d;
        end
    end

    assign regRdData = rdData_q;

    // ====================================================================
    // activity events and timer restart
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            actPrev_q <= 1'b0;
            oscPrev_q <= 1'b0;
        end else begin
            actPrev_q <= activityInput;
            oscPrev_q <= referenceOscillatorInput;
        end
    end

    assign actEvt     = activityInput ^ actPrev_q;                        // any pin change
    assign actRestart = actEvt && ctrl_q[sspc_pkg::ACT_WAKE_BIT];
    assign memRestart = memAccessValid && ctrl_q[sspc_pkg::MEM_WAKE_BIT];
    assign pm.restart = actRestart || memRestart;
    assign pm.enable  = (state_q == sspc_pkg::ST_ACTIVE)
                        && !ctrl_q[sspc_pkg::AUTO_PD_DIS_BIT];
    assign wake       = (state_q == sspc_pkg::ST_STANDBY) && pm.restart;

    // ====================================================================
    // power state machine
    always_comb begin
        state_d   = state_q;
        powerUp_d = 1'b0;
        case (state_q)
            sspc_pkg::ST_ACTIVE: begin
                if (suspendRequest) begin
                    state_d = sspc_pkg::ST_SUSPEND;
                end else if (pm.enable && pm.expired && !pm.restart) begin
                    state_d = sspc_pkg::ST_STANDBY;
                end
            end
            sspc_pkg::ST_STANDBY: begin
                if (suspendRequest) begin
                    state_d = sspc_pkg::ST_SUSPEND;
                end else if (wake || ctrl_q[sspc_pkg::AUTO_PD_DIS_BIT]) begin
                    state_d   = sspc_pkg::ST_ACTIVE;
                    powerUp_d = 1'b1;
                end
            end
            sspc_pkg::ST_SUSPEND: begin
                if (!suspendRequest) begin
                    state_d   = sspc_pkg::ST_ACTIVE;
                    powerUp_d = 1'b1;
                end
            end
            default: begin
                state_d = sspc_pkg::ST_ACTIVE;
            end
        endcase
    end

    // ====================================================================
    // registered outputs follow next state and next control value; suspend clock select uses the current one
    always_comb begin
        dispEn_d   = (state_d == sspc_pkg::ST_ACTIVE);
        refOscEn_d = !((state_d == sspc_pkg::ST_SUSPEND)
                       && !ctrl_d[sspc_pkg::SUSP_CLK_SRC_BIT]);
        pinOe_d    = (state_d == sspc_pkg::ST_SUSPEND)
                     && ctrl_d[sspc_pkg::SUSP_CLK_SRC_BIT];
        suspClk_d  = ctrl_q[sspc_pkg::SUSP_CLK_SRC_BIT] ? pm.divClk
                                                        : slowClockInput;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q    <= sspc_pkg::ST_ACTIVE;
            dispEn_q   <= 1'b1;
            refOscEn_q <= 1'b1;
            pinOe_q    <= 1'b0;
            suspClk_q  <= 1'b0;
            powerUp_q  <= 1'b0;
        end else begin
            state_q    <= state_d;
            dispEn_q   <= dispEn_d;
            refOscEn_q <= refOscEn_d;
            pinOe_q    <= pinOe_d;
            suspClk_q  <= suspClk_d;
            powerUp_q  <= powerUp_d;
        end
    end

    // divider runs only in suspend with the internal source
    assign pm.oscEdge   = referenceOscillatorInput && !oscPrev_q;
    assign pm.divEnable = (state_q == sspc_pkg::ST_SUSPEND)
                          && ctrl_q[sspc_pkg::SUSP_CLK_SRC_BIT];

    assign displayClkEnable  = dispEn_q;
    assign paletteEnable     = dispEn_q;
    assign panelPowerUpStart = powerUp_q;
    assign refOscEnable      = refOscEn_q;
    assign slowClockOe       = pinOe_q;
    assign suspendStatusOutN = !pinOe_q;   // low while driven in suspend
    assign suspendClock      = suspClk_q;

    // ====================================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence sActInStandby;
        (state_q == sspc_pkg::ST_STANDBY) && actEvt && ctrl_q[sspc_pkg::ACT_WAKE_BIT] && !suspendRequest;
    endsequence
    sequence sMemInStandby;
        (state_q == sspc_pkg::ST_STANDBY) && memAccessValid && ctrl_q[sspc_pkg::MEM_WAKE_BIT] && !suspendRequest;
    endsequence
    sequence sWokenUp;
        displayClkEnable && paletteEnable && panelPowerUpStart ##1 !panelPowerUpStart;
    endsequence

    noAutoStandby_a : assert property (
        (state_q == sspc_pkg::ST_ACTIVE && ctrl_q[sspc_pkg::AUTO_PD_DIS_BIT]) |=> state_q != sspc_pkg::ST_STANDBY)
        else $error("standby entered while power-down disabled");
    actIgnored_a : assert property (
        (actEvt && !ctrl_q[sspc_pkg::ACT_WAKE_BIT] && !memRestart) |-> !pm.restart)
        else $error("activity restarted timer while disabled");
    actRestart_a : assert property (
        (actEvt && ctrl_q[sspc_pkg::ACT_WAKE_BIT] && pm.enable) |=> !pm.expired)
        else $error("activity did not restart timer");
    actWake_a : assert property (
        sActInStandby |=> sWokenUp)
        else $error("activity did not wake from standby");
    memIgnored_a : assert property (
        (memAccessValid && !ctrl_q[sspc_pkg::MEM_WAKE_BIT] && !actRestart) |-> !pm.restart)
        else $error("memory access restarted timer while disabled");
    memRestart_a : assert property (
        (memAccessValid && ctrl_q[sspc_pkg::MEM_WAKE_BIT] && pm.enable) |=> !pm.expired)
        else $error("memory access did not restart timer");
    memWake_a : assert property (
        sMemInStandby |=> sWokenUp)
        else $error("memory access did not wake from standby");
    oscOff_a : assert property (
        (state_q == sspc_pkg::ST_SUSPEND && !ctrl_q[sspc_pkg::SUSP_CLK_SRC_BIT]) |-> !refOscEnable && !slowClockOe)
        else $error("oscillator not disabled in suspend");
    statusPin_a : assert property (
        (state_q == sspc_pkg::ST_SUSPEND && ctrl_q[sspc_pkg::SUSP_CLK_SRC_BIT]) |-> slowClockOe && !suspendStatusOutN)
        else $error("suspend status not driven low");
    standbyEntry_a : assert property (
        (pm.enable && pm.expired && !pm.restart && !suspendRequest) |=> !displayClkEnable)
        else $error("timer expiry did not enter standby");

    // ====================================================================
    // suspend, clock source and register port
    suspEntry_a : assert property (
        (state_q != sspc_pkg::ST_SUSPEND && suspendRequest) |=> state_q == sspc_pkg::ST_SUSPEND && !displayClkEnable)
        else $error("suspend request not taken");
    resumePulse_a : assert property (
        (state_q == sspc_pkg::ST_SUSPEND && !suspendRequest) |=> panelPowerUpStart && displayClkEnable)
        else $error("no power-up pulse on resume");
    dispFollows_a : assert property (
        displayClkEnable == (state_q == sspc_pkg::ST_ACTIVE) && paletteEnable == displayClkEnable)
        else $error("display enables out of step with state");
    standbyHold_a : assert property (
        (state_q == sspc_pkg::ST_STANDBY && !pm.restart && !ctrl_q[sspc_pkg::AUTO_PD_DIS_BIT] && !suspendRequest)
        |=> state_q == sspc_pkg::ST_STANDBY)
        else $error("standby left without a wake event");
    oscOn_a : assert property (
        (state_q != sspc_pkg::ST_SUSPEND) |-> refOscEnable)
        else $error("oscillator disabled outside suspend");
    pinReleased_a : assert property (
        (state_q != sspc_pkg::ST_SUSPEND || !ctrl_q[sspc_pkg::SUSP_CLK_SRC_BIT]) |-> !slowClockOe && suspendStatusOutN)
        else $error("slow clock pin driven outside divided suspend");
    extClkFollow_a : assert property (
        !ctrl_q[sspc_pkg::SUSP_CLK_SRC_BIT] |=> suspendClock == $past(slowClockInput))
        else $error("suspend clock not taken from the pin");
    divClkFollow_a : assert property (
        ctrl_q[sspc_pkg::SUSP_CLK_SRC_BIT] |=> suspendClock == $past(pm.divClk))
        else $error("suspend clock not taken from the divider");
    divIdle_a : assert property (
        !pm.divEnable |=> !pm.divClk)
        else $error("divider ran outside divided suspend");
    rdIdle_a : assert property (
        !regRd |=> regRdData == 8'h00)
        else $error("read data not cleared after a read");
    ctrlRead_a : assert property (
        (regRd && isCtrl(regAddr)) |=> regRdData == $past(ctrl_q))
        else $error("control read returned a wrong value");
    ctrlWrite_a : assert property (
        (regWr && isCtrl(regAddr)) |=> ctrl_q == $past(regWrData))
        else $error("control write not stored");
endmodule
`default_nettype wire

// file: dv/sspc_sys_model.sv
// system-side model: activity pin, display memory accesses, oscillator, external slow clock
`timescale 1ns/1ps
`default_nettype none
module sspc_sys_model (
    // clock
    input  wire logic sys_clk,
    // stimulus towards the controller
    output logic      activityInput,
    output logic      memAccessValid,
    output logic      referenceOscillatorInput,
    output logic      extClk
);
    logic [2:0] extDiv;

    // ====================================================================
    // free-running clocks
    initial begin
        activityInput            = 1'b0;
        memAccessValid           = 1'b0;
        referenceOscillatorInput = 1'b0;
        extClk                   = 1'b0;
        extDiv                   = 3'h0;
    end

    // oscillator toggles each cycle, external slow clock every eight
    always @(posedge sys_clk) begin
        referenceOscillatorInput <= ~referenceOscillatorInput;
        extDiv                   <= extDiv + 3'h1;
        if (extDiv == 3'h7) begin
            extClk <= ~extClk;
        end
    end

    // ====================================================================
    // events: one level change, or one single-cycle access
    task automatic pulseActivity;
        @(posedge sys_clk);
        activityInput <= ~activityInput;
    endtask

    task automatic pulseMem;
        @(posedge sys_clk);
        memAccessValid <= 1'b1;
        @(posedge sys_clk);
        memAccessValid <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench of the standby/suspend power controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int T = 64;
    logic       sys_clk, rst, regWr, regRd, suspendRequest;
    logic [7:0] regAddr, regWrData, regRdData, d;
    logic       activityInput, memAccessValid, referenceOscillatorInput, extClk;
    logic       refOscEnable, suspendStatusOutN, slowClockOe, suspendClock;
    logic       displayClkEnable, paletteEnable, panelPowerUpStart;
    wire logic  slowClockInput;
    int         err_total = 0;
    int         n_checks = 0;
    int         n;

    // shared slow clock pin: device drives it only while enabled
    assign slowClockInput = slowClockOe ? suspendStatusOutN : extClk;

    sspc_power_ctrl #(.TIMEOUT_CYC(T)) u_sspc_power_ctrl (
        .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .activityInput(activityInput),
        .memAccessValid(memAccessValid), .suspendRequest(suspendRequest),
        .referenceOscillatorInput(referenceOscillatorInput), .refOscEnable(refOscEnable),
        .slowClockInput(slowClockInput), .suspendStatusOutN(suspendStatusOutN),
        .slowClockOe(slowClockOe), .suspendClock(suspendClock), .displayClkEnable(displayClkEnable),
        .paletteEnable(paletteEnable), .panelPowerUpStart(panelPowerUpStart));

    sspc_sys_model u_sspc_sys_model (
        .sys_clk(sys_clk), .activityInput(activityInput), .memAccessValid(memAccessValid),
        .referenceOscillatorInput(referenceOscillatorInput), .extClk(extClk));

    // ====================================================================
    // clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ====================================================================
    // reporting
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ====================================================================
    // register bus and waits
    task automatic regWrite(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= v;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    task automatic regRead(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask

    // cycles until display clock enable (0) or power-up pulse (1) reaches val, current cycle first
    task automatic waitSig(input int sel, input logic val, output int cnt);
        for (cnt = 1; cnt <= 1000; cnt++) begin
            #1;
            if ((sel == 0 ? displayClkEnable : panelPowerUpStart) === val) begin
                return;
            end
            @(posedge sys_clk);
        end
        check("wait bound", 16'h1, 16'h0);
        test_done();
    endtask

    // oscillator rises seen until the suspend clock next changes
    task automatic oscRises(output int rises);
        logic s0, o0;
        s0    = suspendClock;
        o0    = referenceOscillatorInput;
        rises = 0;
        repeat (1000) begin
            @(posedge sys_clk);
            #1;
            if (referenceOscillatorInput && !o0) begin
                rises++;
            end
            o0 = referenceOscillatorInput;
            if (suspendClock !== s0) begin
                return;
            end
        end
        check("slow clock bound", 16'h1, 16'h0);
        test_done();
    endtask

    // back to active with a fresh timer, then the wanted control value
    task automatic prep(input logic [7:0] v);
        regWrite(sspc_pkg::CTRL_OFFSET, 8'h80);
        regWrite(sspc_pkg::CTRL_OFFSET, v | 8'h20);
        u_sspc_sys_model.pulseMem();
        regWrite(sspc_pkg::CTRL_OFFSET, v);
    endtask

    // ====================================================================
    // scenarios
    task automatic t_regs;
        regRead(sspc_pkg::CTRL_OFFSET, d);
        check("ctrl reset", d, sspc_pkg::CTRL_RESET);
        regWrite(sspc_pkg::CTRL_OFFSET, 8'h5A);
        regWrite(8'h7E, 8'hFF);
        regRead(sspc_pkg::CTRL_OFFSET, d);
        check("ctrl readback", d, 8'h5A);
        @(posedge sys_clk);
        #1 check("read data stands one cycle", regRdData, 8'h00);
        regRead(8'h7E, d);
        check("unmapped read", d, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_ignore;
        prep(8'h00);
        repeat (T / 2) @(posedge sys_clk);
        u_sspc_sys_model.pulseActivity();
        u_sspc_sys_model.pulseMem();
        waitSig(0, 1'b0, n);
        check("events ignored", 16'(n <= T / 2 + 4), 16'h1);
        check("palette off", paletteEnable, 1'b0);
        $display("test ignore done");
    endtask

    task automatic t_wake(input int src);
        prep(src == 0 ? 8'h40 : 8'h20);
        repeat (T / 2) @(posedge sys_clk);
        if (src == 0) u_sspc_sys_model.pulseActivity();
        else u_sspc_sys_model.pulseMem();
        waitSig(0, 1'b0, n);
        check("restart gap", 16'(n >= T - 2 && n <= T + 4), 16'h1);
        repeat (4) @(posedge sys_clk);
        if (src == 0) u_sspc_sys_model.pulseActivity();
        else u_sspc_sys_model.pulseMem();
        waitSig(1, 1'b1, n);
        check("wake latency", 16'(n <= 3), 16'h1);
        check("wake clock", displayClkEnable, 1'b1);
        check("wake palette", paletteEnable, 1'b1);
        @(posedge sys_clk);
        #1 check("power-up pulse ends", panelPowerUpStart, 1'b0);
        $display("test wake done");
    endtask

    task automatic t_disable;
        // test-only setting of the power-down disable
        prep(8'h80);
        repeat (2 * T) @(posedge sys_clk);
        #1 check("no standby", displayClkEnable, 1'b1);
        $display("test disable done");
    endtask

    task automatic t_susp(input logic div);
        logic prev;
        prep(div ? 8'h10 : 8'h00);
        suspendRequest <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 check("osc enable", refOscEnable, div);
        check("pin drive", slowClockOe, div);
        if (div) check("status low", suspendStatusOutN, 1'b0);
        regRead(sspc_pkg::STATUS_OFFSET, d);
        check("suspend state", d[1:0], 2'b10);
        if (div) begin
            oscRises(n);
            oscRises(n);
            check("divide ratio", 16'(2 * n), 16'(sspc_pkg::OSC_DIV_RATIO));
        end else begin
            prev = slowClockInput;
            repeat (20) begin
                @(posedge sys_clk);
                #1 check("external clock", suspendClock, prev);
                prev = slowClockInput;
            end
        end
        @(posedge sys_clk);
        suspendRequest <= 1'b0;
        waitSig(1, 1'b1, n);
        check("resume pulse", 16'(n <= 3), 16'h1);
        check("pin released", slowClockOe, 1'b0);
        check("osc back", refOscEnable, 1'b1);
        $display("test suspend done");
    endtask

    // ====================================================================
    // main sequence
    initial begin
        rst            = 1'b1;
        regWr          = 1'b0;
        regRd          = 1'b0;
        regAddr        = 8'h00;
        regWrData      = 8'h00;
        suspendRequest = 1'b0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_ignore();
        t_wake(0);
        t_wake(1);
        t_disable();
        t_susp(1'b0);
        t_susp(1'b1);
        test_done();
    end
endmodule
`default_nettype wire
